// file: rtl/rdl_lane_config.v
// lane 1 and lane 2 configuration registers and the settings they drive
// assumes the serial bus engine outside decodes frames into byte reads and writes
`timescale 1ns/1ps
`default_nettype none
`include "rdl_regs.vh"

module rdl_lane_config #(
    parameter NUM_LANES = 2
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // register access from the serial bus engine
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_ff,
    output reg reg_rd_valid_ff,
    // global control bits
    input wire control_source_select,
    input wire track_all_off,
    // strap pin levels
    input wire [2:0] strap_eq_code,
    input wire strap_dc_gain,
    input wire [1:0] strap_rx_gain,
    // lane settings, lane 1 in the low slice
    output reg [3*NUM_LANES-1:0] equalizer_strength_code,
    output reg [NUM_LANES-1:0] output_stage_dc_gain,
    output reg [NUM_LANES-1:0] equalizer_dc_gain_sel,
    output reg [2*NUM_LANES-1:0] rx_gain_code,
    output reg [NUM_LANES-1:0] driver_ac_peaking_on,
    output reg [NUM_LANES-1:0] equalizer_stage_off_n,
    output reg [NUM_LANES-1:0] driver_stage_off_n
);

    wire [8*NUM_LANES-1:0] ctrl_all;
    wire [3*NUM_LANES-1:0] enab_all;
    reg [7:0] nxt_rdata;
    integer k;

    // register pairs, one per lane
    genvar g;
    generate
        for (g = 0; g < NUM_LANES; g = g + 1) begin : g_lane
            rdl_lane_regs #(
                .CTRL_ADDR(g == 0 ? `RDL_LANE1_CTRL_ADDR : `RDL_LANE2_CTRL_ADDR),
                .ENAB_ADDR(g == 0 ? `RDL_LANE1_ENAB_ADDR : `RDL_LANE2_ENAB_ADDR)
            ) u_regs (
                .clk_sys(clk_sys),
                .rst(rst),
                .reg_wr_en(reg_wr_en),
                .reg_addr(reg_addr),
                .reg_wdata(reg_wdata),
                .ctrl_ff(ctrl_all[8*g+7:8*g]),
                .enab_ff(enab_all[3*g+2:3*g])
            );
        end
    endgenerate

    // read mux; unmapped addresses answer zero
    always @* begin
        nxt_rdata = `RDL_UNMAPPED_READ;
        for (k = 0; k < NUM_LANES; k = k + 1) begin
            if (reg_addr == (k == 0 ? `RDL_LANE1_CTRL_ADDR : `RDL_LANE2_CTRL_ADDR)) begin
                nxt_rdata = ctrl_all[8*k +: 8];
            end
            if (reg_addr == (k == 0 ? `RDL_LANE1_ENAB_ADDR : `RDL_LANE2_ENAB_ADDR)) begin
                nxt_rdata = {5'h00, enab_all[3*k +: 3]};
            end
        end
    end

    // read data held until the next read
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
            reg_rd_valid_ff <= 1'b0;
        end else begin
            reg_rd_valid_ff <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    // effective lane settings, registered so the analog side sees clean levels
    generate
        for (g = 0; g < NUM_LANES; g = g + 1) begin : g_out
            // lane 1 as source when tracking
            wire [7:0] src_ctrl = track_all_off ? ctrl_all[8*g+7:8*g] : ctrl_all[7:0];
            wire [2:0] src_enab = track_all_off ? enab_all[3*g+2:3*g] : enab_all[2:0];
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    equalizer_strength_code[3*g+2:3*g] <= 3'h0;
                    output_stage_dc_gain[g] <= 1'b0;
                    equalizer_dc_gain_sel[g] <= 1'b0;
                    rx_gain_code[2*g+1:2*g] <= 2'h0;
                    driver_ac_peaking_on[g] <= 1'b0;
                    equalizer_stage_off_n[g] <= 1'b0;
                    driver_stage_off_n[g] <= 1'b0;
                end else if (control_source_select) begin
                    // straps govern
                    // no strap for peaking or stage disables: stages off, no peaking
                    equalizer_strength_code[3*g+2:3*g] <= strap_eq_code;
                    output_stage_dc_gain[g] <= strap_dc_gain;
                    equalizer_dc_gain_sel[g] <= strap_dc_gain;
                    rx_gain_code[2*g+1:2*g] <= strap_rx_gain;
                    driver_ac_peaking_on[g] <= 1'b0;
                    equalizer_stage_off_n[g] <= 1'b0;
                    driver_stage_off_n[g] <= 1'b0;
                end else begin
                    equalizer_strength_code[3*g+2:3*g] <= src_ctrl[`RDL_CTRL_EQ_MSB:`RDL_CTRL_EQ_LSB];
                    output_stage_dc_gain[g] <= src_ctrl[`RDL_CTRL_TXG_BIT];
                    equalizer_dc_gain_sel[g] <= src_ctrl[`RDL_CTRL_EQDC_BIT];
                    // code 10 passed through as is
                    rx_gain_code[2*g+1:2*g] <= src_ctrl[`RDL_CTRL_RXG_MSB:`RDL_CTRL_RXG_LSB];
                    driver_ac_peaking_on[g] <= src_enab[`RDL_ENAB_PEAK_BIT];
                    // same bit meaning on lane 2
                    equalizer_stage_off_n[g] <= src_enab[`RDL_ENAB_EQOFF_BIT];
                    driver_stage_off_n[g] <= src_enab[`RDL_ENAB_DRVOFF_BIT];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// file: include/rdl_regs.vh
// register map constants for the redriver lane configuration bank
// included by bare name; definitions only
`ifndef RDL_REGS_VH
`define RDL_REGS_VH

// register addresses on the serial control bus
`define RDL_LANE1_CTRL_ADDR 8'h05
`define RDL_LANE1_ENAB_ADDR 8'h06
`define RDL_LANE2_CTRL_ADDR 8'h08
`define RDL_LANE2_ENAB_ADDR 8'h09

// reset values
`define RDL_CTRL_RESET 8'h00
`define RDL_ENAB_RESET 3'h0

// control register fields
`define RDL_CTRL_RESERVED_BIT_BIT 7
`define RDL_CTRL_EQ_MSB 6
`define RDL_CTRL_EQ_LSB 4
`define RDL_CTRL_TXG_BIT 3
`define RDL_CTRL_EQDC_BIT 2
`define RDL_CTRL_RXG_MSB 1
`define RDL_CTRL_RXG_LSB 0

// enable register fields
`define RDL_ENAB_PEAK_BIT 2
`define RDL_ENAB_EQOFF_BIT 1
`define RDL_ENAB_DRVOFF_BIT 0
`define RDL_ENAB_WIDTH 3

// value read from an unmapped address
`define RDL_UNMAPPED_READ 8'h00

`endif

// file: rtl/rdl_lane_regs.v
// one lane's control and enable register pair
// assumes a single-cycle write strobe from the serial bus engine
`timescale 1ns/1ps
`default_nettype none
`include "rdl_regs.vh"

module rdl_lane_regs #(
    parameter [7:0] CTRL_ADDR = `RDL_LANE1_CTRL_ADDR,
    parameter [7:0] ENAB_ADDR = `RDL_LANE1_ENAB_ADDR
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // write port
    input wire reg_wr_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    // stored values
    output reg [7:0] ctrl_ff,
    output reg [2:0] enab_ff
);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_ff <= `RDL_CTRL_RESET;
        end else if (reg_wr_en && reg_addr == CTRL_ADDR) begin
            ctrl_ff <= reg_wdata;
        end
    end

    // upper enable bits dropped
    // only three bits are stored, so writes to 7..3 vanish by construction
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enab_ff <= `RDL_ENAB_RESET;
        end else if (reg_wr_en && reg_addr == ENAB_ADDR) begin
            enab_ff <= reg_wdata[`RDL_ENAB_WIDTH-1:0];
        end
    end

endmodule
`default_nettype wire

// file: verif/rdl_lane_config_properties.sv
// port assertions for the lane configuration bank
// bound to every rdl_lane_config instance
`timescale 1ns/1ps
`default_nettype none
module rdl_lane_config_properties #(parameter NUM_LANES = 2) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic reg_rd_valid_ff,
    // globals
    input wire logic control_source_select,
    input wire logic track_all_off,
    // lane settings
    input wire logic [3*NUM_LANES-1:0] equalizer_strength_code,
    input wire logic [2*NUM_LANES-1:0] rx_gain_code,
    input wire logic [NUM_LANES-1:0] driver_ac_peaking_on,
    input wire logic [NUM_LANES-1:0] equalizer_stage_off_n
);
    // one clock domain
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_rd_valid_next: assert property (reg_rd_en |=> reg_rd_valid_ff) else $error("no read valid");
    a_enab_top_zero: assert property (reg_rd_en && reg_addr inside {8'h06, 8'h09} |=> reg_rdata_ff[7:3] == 5'h00)
        else $error("enable top bits set");
    a_unmapped_zero: assert property (reg_rd_en && !(reg_addr inside {8'h05, 8'h06, 8'h08, 8'h09}) |=>
        reg_rdata_ff == 8'h00) else $error("unmapped read");
    a_lane2_readback: assert property (reg_wr_en && reg_addr == 8'h08 ##2 reg_rd_en && reg_addr == 8'h08 |=>
        reg_rdata_ff == $past(reg_wdata, 3)) else $error("lane 2 readback");
    a_lane1_ctrl_out: assert property (reg_wr_en && reg_addr == 8'h05 ##1 !control_source_select |=>
        {equalizer_strength_code[2:0], rx_gain_code[1:0]} == {$past(reg_wdata[6:4], 2), $past(reg_wdata[1:0], 2)})
        else $error("lane 1 fields");
    a_lane1_enab_out: assert property (reg_wr_en && reg_addr == 8'h06 ##1 !control_source_select |=>
        {driver_ac_peaking_on[0], equalizer_stage_off_n[0]} == $past(reg_wdata[2:1], 2)) else $error("lane 1 enables");
    a_lane2_tracks: assert property (!control_source_select && !track_all_off |=>
        rx_gain_code[3:2] == rx_gain_code[1:0]) else $error("no tracking");
    a_strap_quiet: assert property (control_source_select |=> driver_ac_peaking_on == 2'h0)
        else $error("peaking under straps");
    // main scenarios reached
    c_strap: cover property (control_source_select);
    c_track: cover property (!track_all_off && reg_wr_en);
    c_enab_rd: cover property (reg_rd_en && reg_addr == 8'h09);
endmodule
bind rdl_lane_config rdl_lane_config_properties #(.NUM_LANES(NUM_LANES)) u_props (.*);
`default_nettype wire

// file: verif/rdl_host_model.sv
// host on the register port, one-cycle strobes
// expects the one-cycle read answer of the bank
`timescale 1ns/1ps
`default_nettype none
module rdl_host_model (
    // clock
    input wire logic clk_sys,
    // register port
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic reg_rd_valid_ff
);
    initial {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = 18'h00000;
    // released bus is inverted so stale values never pass
    task automatic xfer(input logic wr, input logic [7:0] a, v, output logic ok, output logic [7:0] q);
        @(posedge clk_sys) #1;
        {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {wr, !wr, a, v};
        @(posedge clk_sys) #1;
        {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {2'b00, ~a, ~v};
        ok = wr || reg_rd_valid_ff;
        q = reg_rdata_ff;
    endtask
endmodule
`default_nettype wire

// file: verif/rdl_lane_config_bench.sv
// self-checking bench for the lane configuration bank
// host model on the register port, checker bound
`timescale 1ns/1ps
`default_nettype none
module rdl_lane_config_bench;
    localparam logic [7:0] AD [5] = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h07};
    localparam logic [7:0] MK [5] = '{8'hFF, 8'h07, 8'hFF, 8'h07, 8'h00};
    logic clk_sys = 1'b0, rst = 1'b1, control_source_select = 1'b0, track_all_off = 1'b1, ok;
    logic [2:0] strap_eq_code = 3'h0;
    logic [1:0] strap_rx_gain = 2'h0;
    logic strap_dc_gain = 1'b0;
    logic [7:0] q, d, s, m [5];
    wire logic reg_wr_en, reg_rd_en, reg_rd_valid_ff;
    wire logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
    wire logic [19:0] o;
    int n_fail = 0, n_tests = 0, k, i;
    // 25 MHz
    always #20 clk_sys = ~clk_sys;
    rdl_host_model u_host (.*);
    rdl_lane_config u_rdl_lane_config (.*, .equalizer_strength_code(o[19:14]),
        .output_stage_dc_gain(o[13:12]), .equalizer_dc_gain_sel(o[11:10]), .rx_gain_code(o[9:6]),
        .driver_ac_peaking_on(o[5:4]), .equalizer_stage_off_n(o[3:2]), .driver_stage_off_n(o[1:0]));
    // lane outputs expected from two control and two enable bytes
    function automatic logic [19:0] lanes(input logic [7:0] a, b, c, e);
        return {c[6:4], a[6:4], c[3], a[3], c[2], a[2], c[1:0], a[1:0], e[2], b[2], e[1], b[1], e[0], b[0]};
    endfunction
    task automatic chk(input logic [19:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        if (n_fail == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one byte transfer, reads compared with the model
    task automatic acc(input logic wr, input int j, input logic [7:0] v);
        u_host.xfer(wr, AD[j], v, ok, q);
        if (!ok) begin
            n_fail++;
            results;
        end
        if (wr) m[j] = v & MK[j];
        else chk({12'h000, q}, {12'h000, m[j]});
    endtask
    initial begin
        void'($urandom(11));
        for (k = 0; k < 5; k++) m[k] = 8'h00;
        repeat (3) @(posedge clk_sys);
        #1 rst = 1'b0;
        for (k = 0; k < 5; k++) acc(0, k, 8'h00);
        for (k = 0; k < 80; k++) begin
            i = (k < 5) ? k : $urandom % 5;
            d = (k < 5) ? 8'hFF : 8'($urandom);
            // control bit 7 clear, no gain code 10
            if (MK[i] == 8'hFF) d = {1'b0, d[6:1], d[1] | d[0]};
            acc(1, i, d);
            acc(0, i, 8'h00);
            {control_source_select, track_all_off, strap_eq_code, strap_dc_gain, strap_rx_gain} = 8'($urandom);
            repeat (2) @(posedge clk_sys);
            #1;
            // one dc gain strap feeds both dc gain settings of every lane
            s = {1'b0, strap_eq_code, strap_dc_gain, strap_dc_gain, strap_rx_gain};
            if (control_source_select) chk(o, lanes(s, 8'h00, s, 8'h00));
            else if (!track_all_off) chk(o, lanes(m[0], m[1], m[0], m[1]));
            else chk(o, lanes(m[0], m[1], m[2], m[3]));
        end
        results;
    end
endmodule
`default_nettype wire
